/* File: bbh_services.sv */
`default_nettype none
// How it works
// - reset request: reinitialise, reset indication on entering normal
// - polling slot collision sets clash flag
// - corrupted host bytes set input fault flag
// - sent zero read one sets echo flag
// - wrongly ordered requests set order fault flag
// - thermal warning sets overheat flag
// - busy mode answers own address with busy
// - host acknowledge request ends busy mode
// - quit busy restores positive acknowledge
// - monitor state forwards everything until reset
// - auto acknowledge: iack, nack on receive error
// - set address stores; first enables, configure indication
// - address applied on idle bus; reset disables
// - configure indication shows five feature bits
// - busy and nack retry limits, both three at reset, set repetition request changes them
// - busy retry after 150 idle bit times
// - nack, bad or missing ack: 50 bit retry
// - limit exhausted: negative confirmation, stop retrying
// - system status shows supply, oscillator, thermal bits
// - low status bits give operating mode
// - warning pin low on bad supply or heat
// - state indication flag order, low bits 111
// - ack bytes forwarded only when monitoring
module bbh_services
    import bbh_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        LINEAR_REG_OK,
    input  wire logic        CONVERTER_TWO_OK,
    input  wire logic        LINE_VOLTAGE_OK,
    input  wire logic        TANK_CAP_OK,
    input  wire logic        OSCILLATOR_OK,
    input  wire logic        OVERHEAT_PRESENT,
    input  wire logic [1:0]  OP_MODE,
    input  wire logic        AUTO_POLL_FLAG,
    input  wire logic        CRC_FLAG,
    input  wire logic        MARKER_FLAG,
    input  wire logic        BUS_IDLE,
    input  wire logic        POLL_CLASH,
    input  wire logic        HOST_BYTE_FAULT,
    input  wire logic        ECHO_MISMATCH,
    input  wire logic        RX_BYTE_VALID,
    input  wire logic [7:0]  RX_BYTE,
    input  wire logic        RX_BYTE_IS_ACK,
    input  wire logic        RX_CHECK,
    input  wire logic [15:0] RX_DEST,
    input  wire logic        RX_DEST_GROUP,
    input  wire logic        RX_ERROR,
    input  wire logic        TX_END,
    input  wire logic        TX_ACK_VALID,
    input  wire bbh_ack_e    TX_ACK_CLASS,
    output logic             FWD_VALID,
    output logic      [7:0]  FWD_BYTE,
    output logic             ACK_SEND,
    output bbh_ack_e         ACK_CODE,
    output logic             RETRANSMIT,
    output logic             RESET_REQ,
    output logic             POWER_FAIL_WARNING_N
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  pin_s1;
        logic [5:0]  pin_s2;
        logic [1:0]  mode_q;
        logic        rst_wait;
        logic        rst_ind;
        logic        cfg_ind;
        logic        state_ind;
        logic        stat_ind;
        logic        stat2_ind;
        logic        con_ind;
        logic        con_ok;
        bbh_flags_s  flags;
        logic        busy;
        logic        auto_ack;
        logic        monitor;
        logic [15:0] own_addr;
        logic [15:0] new_addr;
        logic        addr_pend;
        logic [1:0]  need;
        logic        in_setaddr;
        logic [2:0]  busy_lim;
        logic [2:0]  nack_lim;
        logic [2:0]  busy_cnt;
        logic [2:0]  nack_cnt;
        bbh_retry_e  rstate;
        logic [15:0] cyc_cnt;
        logic [7:0]  bit_cnt;
        logic        ack_send;
        bbh_ack_e    ack_code;
        logic        retx;
        logic        rst_req;
        logic        fwd_v;
        logic [7:0]  fwd_b;
        logic [8:0]  ind;
        logic        dp_wr;
        logic [3:0]  dp_ofs;
        logic [31:0] hrdata;
        logic        pfw_n;
    } bbh_state_s;

    bbh_state_s s;
    bbh_state_s next_s;

    function automatic logic [7:0] stat_byte(input logic [5:0] p,
                                             input logic [1:0] m);
        stat_byte = {p, m};
    endfunction

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

    logic [7:0]  sys_stat;
    logic        addr_ph;
    logic        rd_ind;
    logic [7:0]  wbyte;
    logic        entered_normal;
    logic        bit_tick;
    logic        retry_busy;
    logic        retry_nack;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        sys_stat = stat_byte(s.pin_s2, OP_MODE);
        addr_ph = HSEL & HTRANS[1] & HREADY;
        rd_ind = addr_ph & ~HWRITE & (HADDR[3:0] == OFS_IND);
        wbyte = HWDATA[7:0];
        entered_normal = (OP_MODE == MODE_NORMAL) && (s.mode_q != MODE_NORMAL);
        bit_tick = (s.cyc_cnt == BIT_LAST);
        retry_busy = 1'b0;
        retry_nack = 1'b0;

        // pins pass two flops before use
        next_s.pin_s1 = {LINEAR_REG_OK, CONVERTER_TWO_OK, LINE_VOLTAGE_OK,
                         TANK_CAP_OK, OSCILLATOR_OK, OVERHEAT_PRESENT};
        next_s.pin_s2 = s.pin_s1;
        next_s.mode_q = OP_MODE;
        next_s.ack_send = 1'b0;
        next_s.retx = 1'b0;
        next_s.rst_req = 1'b0;
        next_s.pfw_n = ~((sys_stat[7:3] != 5'h1f) | sys_stat[2]);

        // bus bytes: ack bytes only while monitoring
        next_s.fwd_v = RX_BYTE_VALID & (~RX_BYTE_IS_ACK | s.monitor);
        next_s.fwd_b = RX_BYTE_VALID ? RX_BYTE : s.fwd_b;

        // ------------------------------------------------------------------
        // automatic acknowledge
        // ------------------------------------------------------------------
        if (RX_CHECK && s.auto_ack && !s.monitor &&
            (RX_DEST_GROUP || RX_DEST == s.own_addr)) begin
            next_s.ack_send = 1'b1;
            if (RX_ERROR) begin
                next_s.ack_code = ACK_NACK;
            end else if (s.busy && !RX_DEST_GROUP) begin
                next_s.ack_code = ACK_BUSY;
            end else begin
                next_s.ack_code = ACK_OK;
            end
        end

        // new address waits for a quiet bus so a frame in flight is
        // acknowledged against one consistent address
        if (s.addr_pend && BUS_IDLE) begin
            next_s.addr_pend = 1'b0;
            next_s.own_addr = s.new_addr;
            next_s.auto_ack = 1'b1;
            if (!s.auto_ack) begin
                next_s.cfg_ind = 1'b1;
            end
        end

        // ------------------------------------------------------------------
        // sticky flags, set wins over the clear on report
        // ------------------------------------------------------------------
        if (s.state_ind && !s.ind[IND_VALID_BIT] || rd_ind && s.state_ind) begin
            next_s.flags = '0;
        end
        if (POLL_CLASH) next_s.flags.clash = 1'b1;
        if (HOST_BYTE_FAULT) next_s.flags.host_fault = 1'b1;
        if (ECHO_MISMATCH) next_s.flags.echo_err = 1'b1;
        if (s.pin_s2[0]) next_s.flags.heat = 1'b1;

        // ------------------------------------------------------------------
        // retransmission
        // ------------------------------------------------------------------
        next_s.cyc_cnt = bit_tick ? '0 : s.cyc_cnt + 16'h0001;
        if (bit_tick && s.bit_cnt != 8'hff) begin
            next_s.bit_cnt = s.bit_cnt + 8'h01;
        end
        case (s.rstate)
            RT_IDLE: begin
                if (TX_END) begin
                    next_s.rstate = RT_ACKW;
                    next_s.cyc_cnt = '0;
                    next_s.bit_cnt = '0;
                end
            end
            RT_ACKW: begin
                if (TX_ACK_VALID) begin
                    case (TX_ACK_CLASS)
                        ACK_OK: begin
                            next_s.con_ind = 1'b1;
                            next_s.con_ok = 1'b1;
                            next_s.busy_cnt = '0;
                            next_s.nack_cnt = '0;
                            next_s.rstate = RT_IDLE;
                        end
                        ACK_BUSY: retry_busy = 1'b1;
                        default: retry_nack = 1'b1;
                    endcase
                end else if (s.bit_cnt >= ACK_WAIT_BITS) begin
                    retry_nack = 1'b1;
                end
            end
            RT_GAPB, RT_GAPN: begin
                if (!BUS_IDLE) begin
                    next_s.cyc_cnt = '0;
                    next_s.bit_cnt = '0;
                end else if (s.bit_cnt >= ((s.rstate == RT_GAPB) ?
                             GAP_BUSY_BITS : GAP_NACK_BITS)) begin
                    next_s.retx = 1'b1;
                    next_s.rstate = RT_IDLE;
                end
            end
            default: next_s.rstate = RT_IDLE;
        endcase
        if (retry_busy || retry_nack) begin
            next_s.cyc_cnt = '0;
            next_s.bit_cnt = '0;
            if (retry_busy && s.busy_cnt < s.busy_lim) begin
                next_s.busy_cnt = s.busy_cnt + 3'h1;
                next_s.rstate = RT_GAPB;
            end else if (retry_nack && s.nack_cnt < s.nack_lim) begin
                next_s.nack_cnt = s.nack_cnt + 3'h1;
                next_s.rstate = RT_GAPN;
            end else begin
                next_s.con_ind = 1'b1;
                next_s.con_ok = 1'b0;
                next_s.busy_cnt = '0;
                next_s.nack_cnt = '0;
                next_s.rstate = RT_IDLE;
            end
        end

        // ------------------------------------------------------------------
        // indication slot, popped by reading it
        // ------------------------------------------------------------------
        if (rd_ind) next_s.ind[IND_VALID_BIT] = 1'b0;
        if (entered_normal && s.rst_wait) begin
            next_s.rst_wait = 1'b0;
            next_s.rst_ind = 1'b1;
        end
        if (!s.ind[IND_VALID_BIT] || rd_ind) begin
            if (s.rst_ind) begin
                next_s.ind = {1'b1, IND_RESET};
                next_s.rst_ind = 1'b0;
            end else if (s.cfg_ind) begin
                next_s.ind = {1'b1, 1'b0, s.busy, s.auto_ack, AUTO_POLL_FLAG,
                              CRC_FLAG, MARKER_FLAG, IND_CFG_LO};
                next_s.cfg_ind = 1'b0;
            end else if (s.con_ind) begin
                next_s.ind = {1'b1, s.con_ok, IND_CON_LO};
                next_s.con_ind = 1'b0;
            end else if (s.stat2_ind) begin
                next_s.ind = {1'b1, sys_stat};
                next_s.stat2_ind = 1'b0;
            end else if (s.state_ind) begin
                next_s.ind = {1'b1, s.flags, IND_STATE_LO};
                next_s.state_ind = 1'b0;
            end else if (s.stat_ind) begin
                next_s.ind = {1'b1, IND_SYSSTAT};
                next_s.stat_ind = 1'b0;
                next_s.stat2_ind = 1'b1;
            end
        end

        // ------------------------------------------------------------------
        // host requests, written one byte at a time
        // ------------------------------------------------------------------
        if (s.dp_wr && s.dp_ofs == OFS_REQ) begin
            if (s.need != 2'h0) begin
                next_s.need = s.need - 2'h1;
                if (s.in_setaddr) begin
                    // third byte is a dummy and is dropped
                    if (s.need == SETADDR_BYTES) begin
                        next_s.new_addr[15:8] = wbyte;
                    end else if (s.need == 2'h2) begin
                        next_s.new_addr[7:0] = wbyte;
                    end else begin
                        next_s.addr_pend = 1'b1;
                    end
                end else begin
                    // bits 3 and 7 are trusted to be zero
                    next_s.busy_lim = wbyte[6:4];
                    next_s.nack_lim = wbyte[2:0];
                end
            end else if (wbyte[7:3] == REQ_ACKN_HI) begin
                next_s.busy = 1'b0;
            end else begin
                case (wbyte)
                    REQ_RESET: begin
                        next_s = '0;
                        next_s.pin_s1 = s.pin_s1;
                        next_s.pin_s2 = s.pin_s2;
                        next_s.mode_q = MODE_NORMAL;
                        next_s.rst_wait = 1'b1;
                        next_s.rst_req = 1'b1;
                        next_s.busy_lim = REP_INIT;
                        next_s.nack_lim = REP_INIT;
                        next_s.pfw_n = s.pfw_n;
                    end
                    REQ_STATE: begin
                        if (s.state_ind) next_s.flags.order_err = 1'b1;
                        next_s.state_ind = 1'b1;
                    end
                    REQ_SYSSTAT: begin
                        if (s.stat_ind || s.stat2_ind) begin
                            next_s.flags.order_err = 1'b1;
                        end
                        next_s.stat_ind = 1'b1;
                    end
                    REQ_SETBUSY: begin
                        if (s.auto_ack) next_s.busy = 1'b1;
                    end
                    REQ_QUITBSY: next_s.busy = 1'b0;
                    REQ_MONITOR: next_s.monitor = 1'b1;
                    REQ_SETADDR: begin
                        next_s.need = SETADDR_BYTES;
                        next_s.in_setaddr = 1'b1;
                    end
                    REQ_SETREP: begin
                        next_s.need = SETREP_BYTES;
                        next_s.in_setaddr = 1'b0;
                    end
                    default: next_s.flags.host_fault = 1'b1;
                endcase
            end
        end

        // ------------------------------------------------------------------
        // bus slave, zero wait states, read data from flops
        // ------------------------------------------------------------------
        next_s.dp_wr = addr_ph & HWRITE;
        next_s.dp_ofs = HADDR[3:0];
        if (addr_ph && !HWRITE) begin
            case (HADDR[3:0])
                OFS_IND: next_s.hrdata = {23'h0, s.ind};
                OFS_STATUS: next_s.hrdata = {s.busy_lim, s.nack_lim,
                    s.monitor, s.busy, s.auto_ack, 3'h0, s.flags, s.rstate,
                    s.ind[IND_VALID_BIT], s.addr_pend, 3'h0, sys_stat};
                OFS_ADDR: next_s.hrdata = {16'h0, s.own_addr};
                default: next_s.hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s <= '0;
            s.busy_lim <= REP_INIT;
            s.nack_lim <= REP_INIT;
            s.pfw_n <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign HRDATA = s.hrdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign FWD_VALID = s.fwd_v;
    assign FWD_BYTE = s.fwd_b;
    assign ACK_SEND = s.ack_send;
    assign ACK_CODE = s.ack_code;
    assign RETRANSMIT = s.retx;
    assign RESET_REQ = s.rst_req;
    assign POWER_FAIL_WARNING_N = s.pfw_n;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence req_written(logic [7:0] c);
        s.dp_wr && s.dp_ofs == OFS_REQ && s.need == 2'h0 && wbyte == c;
    endsequence

    reset_clears_a: assert property (req_written(REQ_RESET) |=>
        !s.busy && !s.auto_ack && !s.monitor && s.busy_lim == REP_INIT)
        else $error("reset request left modes set");
    busy_needs_ack_a: assert property (
        req_written(REQ_SETBUSY) and !s.auto_ack
        |=> s.busy == $past(s.busy))
        else $error("busy set without auto acknowledge");
    busy_ack_a: assert property (RX_CHECK && s.auto_ack && s.busy
        && !RX_ERROR && !RX_DEST_GROUP && RX_DEST == s.own_addr
        && !s.monitor
        |=> ACK_SEND && ACK_CODE == ACK_BUSY)
        else $error("busy mode did not answer busy");
    nack_on_err_a: assert property (RX_CHECK && s.auto_ack && RX_ERROR
        && RX_DEST_GROUP && !s.monitor |=> ACK_SEND && ACK_CODE == ACK_NACK)
        else $error("receive error did not give nack");
    ack_filter_a: assert property (RX_BYTE_VALID && RX_BYTE_IS_ACK
        |=> FWD_VALID == $past(s.monitor))
        else $error("ack byte forwarding wrong");
    addr_idle_a: assert property ($rose(s.auto_ack) |->
        $past(BUS_IDLE) && $past(s.addr_pend))
        else $error("auto acknowledge changed off idle bus");
    pfw_pin_a: assert property (##2 POWER_FAIL_WARNING_N ==
        ($past(sys_stat[7:3]) == 5'h1f && !$past(sys_stat[2])))
        else $error("power fail pin wrong");
    sequence busy_outcome;
        s.rstate == RT_ACKW && TX_ACK_VALID && TX_ACK_CLASS == ACK_BUSY;
    endsequence
    busy_gap_a: assert property (busy_outcome
        and s.busy_cnt < s.busy_lim
        |=> s.rstate == RT_GAPB && s.bit_cnt == 8'h00)
        else $error("busy retry did not wait gap");
    exhaust_a: assert property (busy_outcome
        and s.busy_cnt >= s.busy_lim
        |=> s.con_ind && !s.con_ok && s.rstate == RT_IDLE)
        else $error("exhausted retries not confirmed negative");
    ack_timeout_a: assert property (s.rstate == RT_ACKW && !TX_ACK_VALID
        && s.bit_cnt >= ACK_WAIT_BITS && s.nack_cnt < s.nack_lim
        |=> s.rstate == RT_GAPN)
        else $error("ack timeout not treated as nack");
endmodule
`default_nettype wire

/* File: bbh_pkg.sv */
`default_nettype none
package bbh_pkg;
    // ------------------------------------------------------------------
    // register map, word aligned
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_REQ    = 4'h0;
    localparam logic [3:0] OFS_IND    = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_ADDR   = 4'hc;
    localparam int         IND_VALID_BIT = 8;

    // ------------------------------------------------------------------
    // request codes
    // ------------------------------------------------------------------
    localparam logic [7:0] REQ_RESET   = 8'h01;
    localparam logic [7:0] REQ_STATE   = 8'h02;
    localparam logic [7:0] REQ_SETBUSY = 8'h21;
    localparam logic [7:0] REQ_QUITBSY = 8'h22;
    localparam logic [7:0] REQ_MONITOR = 8'h05;
    localparam logic [7:0] REQ_SYSSTAT = 8'h0d;
    localparam logic [7:0] REQ_SETADDR = 8'hf1;
    localparam logic [7:0] REQ_SETREP  = 8'hf2;
    localparam logic [4:0] REQ_ACKN_HI = 5'h02;
    localparam logic [1:0] SETADDR_BYTES = 2'h3;
    localparam logic [1:0] SETREP_BYTES  = 2'h1;

    // ------------------------------------------------------------------
    // indication codes
    // ------------------------------------------------------------------
    localparam logic [7:0] IND_RESET   = 8'h03;
    localparam logic [2:0] IND_STATE_LO = 3'h7;
    localparam logic [1:0] IND_CFG_LO  = 2'h1;
    localparam logic [7:0] IND_SYSSTAT = 8'h4b;
    localparam logic [6:0] IND_CON_LO  = 7'h0b;

    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [2:0] REP_INIT    = 3'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int BIT_TIME_NS   = 104167;
    localparam int BIT_CYCLES_DEF = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ACK_WAIT_BITS = 8'd30;
    localparam logic [7:0] GAP_BUSY_BITS = 8'd150;
    localparam logic [7:0] GAP_NACK_BITS = 8'd50;

    typedef enum logic [1:0] {
        ACK_OK = 2'b00, ACK_BUSY = 2'b01, ACK_NACK = 2'b10, ACK_BAD = 2'b11
    } bbh_ack_e;

    typedef enum logic [1:0] {
        RT_IDLE = 2'b00, RT_ACKW = 2'b01, RT_GAPB = 2'b10, RT_GAPN = 2'b11
    } bbh_retry_e;

    typedef struct packed {
        logic clash;
        logic host_fault;
        logic echo_err;
        logic order_err;
        logic heat;
    } bbh_flags_s;
endpackage
`default_nettype wire

/* File: bbh_host.sv */
`default_nettype none
module bbh_host
    import bbh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel = 1'b1,
    output var  logic [31:0] haddr = 32'h0,
    output var  logic [1:0]  htrans = 2'h0,
    output var  logic        hwrite = 1'b0,
    output var  logic [2:0]  hsize = 3'h2,
    output var  logic [31:0] hwdata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // released data is inverted so a stale byte can never pass as fresh
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] c);
        logic [31:0] q;
        xfer(1'b1, OFS_REQ, {24'h0, c}, q);
    endtask
    task automatic rep(input logic [2:0] b, n);
        wr(REQ_SETREP);
        wr({1'b0, b, 1'b0, n});
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h", $time, (a)); end end
module testbench
    import bbh_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, idle = 1'b0, clash = 1'b0, echo = 1'b0;
    logic heat = 1'b0, hfault = 1'b0;
    logic rx_v = 1'b0, rx_a = 1'b0, chk = 1'b0, grp = 1'b0, rx_e = 1'b0;
    logic tx_e = 1'b0, tx_v = 1'b0, crc = 1'b1, sel, wrt, rdy, resp;
    logic fwd_v, ack_s, retx, rreq, pfw_n;
    logic [1:0] mode = MODE_NORMAL, trans;
    logic [2:0] size;
    logic [4:0] sup = 5'h1d;
    logic [7:0] fwd_b;
    logic [15:0] dest = 16'h0;
    logic [31:0] addr, wdata, rdata, q;
    bbh_ack_e cls = ACK_OK, ack_c;
    int err_count = 0, num_checks = 0, cyc = 0;
    bbh_host u_host (.clk(clk), .hready(rdy), .hrdata(rdata), .hsel(sel),
        .haddr(addr), .htrans(trans), .hwrite(wrt), .hsize(size),
        .hwdata(wdata));
    bbh_services #(.BIT_CYCLES(4)) u_bbh_services (.CLK_SYS(clk),
        .SYS_RST(rst), .HSEL(sel), .HADDR(addr), .HTRANS(trans),
        .HWRITE(wrt), .HSIZE(size), .HWDATA(wdata), .HREADY(rdy),
        .HRDATA(rdata), .HREADYOUT(rdy), .HRESP(resp),
        .LINEAR_REG_OK(sup[4]), .CONVERTER_TWO_OK(sup[3]),
        .LINE_VOLTAGE_OK(sup[2]), .TANK_CAP_OK(sup[1]),
        .OSCILLATOR_OK(sup[0]), .OVERHEAT_PRESENT(heat), .OP_MODE(mode),
        .AUTO_POLL_FLAG(1'b0), .CRC_FLAG(crc), .MARKER_FLAG(1'b0),
        .BUS_IDLE(idle), .POLL_CLASH(clash), .HOST_BYTE_FAULT(hfault),
        .ECHO_MISMATCH(echo), .RX_BYTE_VALID(rx_v), .RX_BYTE(8'hcc),
        .RX_BYTE_IS_ACK(rx_a), .RX_CHECK(chk), .RX_DEST(dest),
        .RX_DEST_GROUP(grp), .RX_ERROR(rx_e), .TX_END(tx_e),
        .TX_ACK_VALID(tx_v), .TX_ACK_CLASS(cls), .FWD_VALID(fwd_v),
        .FWD_BYTE(fwd_b), .ACK_SEND(ack_s), .ACK_CODE(ack_c),
        .RETRANSMIT(retx), .RESET_REQ(rreq), .POWER_FAIL_WARNING_N(pfw_n));
    always #2.5 clk = ~clk;
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // the longest wait is the 1000-cycle poll for a retransmit that never comes, well under this ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
        repeat (2) @(posedge clk);
        u_host.xfer(1'b0, a, 32'h0, q);
        `CHK(q & m, e)
    endtask
    task automatic ack(input logic [15:0] d, input logic g, er, s,
                       input bbh_ack_e c);
        @(posedge clk);
        dest <= d;
        grp <= g;
        rx_e <= er;
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
        @(negedge clk);
        `CHK({ack_s, s ? ack_c : ACK_OK}, {s, c})
    endtask
    task automatic rx(input logic a, f);
        @(posedge clk);
        rx_a <= a;
        rx_v <= 1'b1;
        @(posedge clk);
        rx_v <= 1'b0;
        @(negedge clk);
        `CHK({fwd_v, fwd_b & {8{f}}}, {f, 8'hcc & {8{f}}})
    endtask
    task automatic tx(input bbh_ack_e c, input int lo);
        int n;
        n = 0;
        @(posedge clk);
        tx_e <= 1'b1;
        @(posedge clk);
        tx_e <= 1'b0;
        tx_v <= 1'b1;
        cls <= c;
        @(posedge clk);
        tx_v <= 1'b0;
        while (retx !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= lo && n < lo + 40, lo > 0)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFS_STATUS, 32'hff80_0000, 32'h6c00_0000);
        `CHK(pfw_n, 1'b0)
        u_host.wr(REQ_SYSSTAT);
        rd(OFS_IND, 32'h1ff, 32'h14b);
        rd(OFS_IND, 32'h1ff, 32'h1eb);
        sup <= 5'h1f;
        repeat (4) @(posedge clk);
        `CHK(pfw_n, 1'b1)
        clash <= 1'b1;
        echo <= 1'b1;
        heat <= 1'b1;
        hfault <= 1'b1;
        @(posedge clk);
        clash <= 1'b0;
        echo <= 1'b0;
        heat <= 1'b0;
        hfault <= 1'b0;
        u_host.wr(REQ_STATE);
        rd(OFS_IND, 32'h1ff, 32'h1ef);
        u_host.wr(REQ_SETADDR);
        u_host.wr(8'h12);
        u_host.wr(8'h34);
        u_host.wr(8'h5a);
        rd(OFS_ADDR, 32'hffff, 32'h0);
        idle <= 1'b1;
        rd(OFS_ADDR, 32'hffff, 32'h1234);
        rd(OFS_IND, 32'h1ff, 32'h129);
        ack(16'h1234, 1'b0, 1'b0, 1'b1, ACK_OK);
        ack(16'h0901, 1'b1, 1'b0, 1'b1, ACK_OK);
        ack(16'h1234, 1'b0, 1'b1, 1'b1, ACK_NACK);
        u_host.wr(REQ_SETBUSY);
        ack(16'h1234, 1'b0, 1'b0, 1'b1, ACK_BUSY);
        u_host.wr({REQ_ACKN_HI, 3'h0});
        ack(16'h1234, 1'b0, 1'b0, 1'b1, ACK_OK);
        u_host.wr(REQ_SETBUSY);
        u_host.wr(REQ_QUITBSY);
        ack(16'h1234, 1'b0, 1'b0, 1'b1, ACK_OK);
        u_host.rep(3'h1, 3'h2);
        tx(ACK_BUSY, 600);
        tx(ACK_BUSY, 0);
        tx(ACK_NACK, 200);
        tx(ACK_BAD, 200);
        tx(ACK_NACK, 0);
        rd(OFS_IND, 32'h1ff, 32'h10b);
        rx(1'b1, 1'b0);
        rx(1'b0, 1'b1);
        u_host.wr(REQ_MONITOR);
        rx(1'b1, 1'b1);
        ack(16'h1234, 1'b0, 1'b0, 1'b0, ACK_OK);
        u_host.wr(REQ_RESET);
        rd(OFS_STATUS, 32'hff80_0000, 32'h6c00_0000);
        ack(16'h1234, 1'b0, 1'b0, 1'b0, ACK_OK);
        mode <= 2'h1;
        repeat (3) @(posedge clk);
        mode <= MODE_NORMAL;
        rd(OFS_IND, 32'h1ff, 32'h103);
        results();
    end
endmodule
`default_nettype wire
